// file: hdl/chan_enable_defs.svh
// offsets, field positions and reset values of the channel enable bank
`ifndef CHAN_ENABLE_DEFS_SVH
`define CHAN_ENABLE_DEFS_SVH
// printed offsets step by one, not by four: they are word indexes
`define ENABLE_GROUPS_A_B_IDX   8'h40
`define ENABLE_GROUPS_C_D_IDX   8'h41
`define ENABLE_GROUPS_E_F_IDX   8'h42
`define ENABLE_GROUPS_G_H_IDX   8'h43
`define ENABLE_REG_COUNT        4
`define ENABLE_LO_POS           0
`define ENABLE_HI_POS           4
`define ENABLE_WRITABLE_MASK    8'h77
`define ENABLE_RESET_VALUE      8'h00
`define ENABLE_UNMAPPED_READ    32'h0000_0000
`endif

// file: hdl/chan_enable_pkg.sv
// types for the channel enable bank
package chan_enable_pkg;
    typedef logic [7:0] enable_byte_t;
    // one avalon request as seen by the slave
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } bus_req_s;
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_e;
endpackage

// file: hdl/channel_output_enable_bank.sv
// register bank of the 24 per-channel output enables, avalon-mm slave
// Operation
// - each output channel has one read/write enable bit, 0 off, 1 on
// - index 41h holds group D ch2..0 in bits 6..4, group C in 2..0
// - index 42h holds group F ch2..0 in bits 6..4, group E in 2..0
// - index 43h holds group H ch2..0 in bits 6..4, group G in 2..0
// - index 40h holds group B ch2..0 in bits 6..4, group A in 2..0
// - reset clears all enable bits, every output starts disabled
`timescale 1ns/10ps
`include "chan_enable_defs.svh"
module channel_output_enable_bank (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [23:0] channelOn
);
    chan_enable_pkg::bus_req_s     req;
    chan_enable_pkg::bus_state_e   busState;
    chan_enable_pkg::enable_byte_t enables [`ENABLE_REG_COUNT];
    logic [1:0]                    hitIdx;
    logic                          hit;
    logic [2:0]                    hitCode;

    // word index to register number; used by read and write paths
    function automatic logic [2:0] decode(input logic [7:0] addr);
        case (addr)
            `ENABLE_GROUPS_A_B_IDX: decode = 3'b100;
            `ENABLE_GROUPS_C_D_IDX: decode = 3'b101;
            `ENABLE_GROUPS_E_F_IDX: decode = 3'b110;
            `ENABLE_GROUPS_G_H_IDX: decode = 3'b111;
            default:                decode = 3'b000;
        endcase
    endfunction

    assign req = '{address, read, write, byteenable, writedata};
    // one decode shared by the read and write paths
    assign hitCode = decode(req.address);
    assign hit = hitCode[2];
    assign hitIdx = hitCode[1:0];

    // one wait cycle per access: waitrequest drops in the answer cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busState <= chan_enable_pkg::BUS_IDLE;
        end else begin
            case (busState)
                chan_enable_pkg::BUS_IDLE: begin
                    if (req.read || req.write) begin
                        busState <= chan_enable_pkg::BUS_ANSWER;
                    end
                end
                chan_enable_pkg::BUS_ANSWER: busState <= chan_enable_pkg::BUS_IDLE;
                default:                     busState <= chan_enable_pkg::BUS_IDLE;
            endcase
        end
    end

    // waitrequest high except in the answer cycle; registered output
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(busState == chan_enable_pkg::BUS_IDLE && (req.read || req.write));
        end
    end

    // enable storage; only byte lane 0 carries data, reserved bits masked
    // the write lands at the edge where the master sees waitrequest low, never earlier
    generate
        for (genvar g = 0; g < `ENABLE_REG_COUNT; g++) begin : gen_reg
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    enables[g] <= `ENABLE_RESET_VALUE;
                end else if (busState == chan_enable_pkg::BUS_ANSWER && req.write && !req.read && hit
                             && hitIdx == 2'(g) && req.byteenable[0]) begin
                    enables[g] <= req.writedata[7:0] & `ENABLE_WRITABLE_MASK;
                end
            end
            // low nibble group first, then high nibble group, per register
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    channelOn[6*g +: 6] <= 6'h0;
                end else begin
                    channelOn[6*g +: 3]     <= enables[g][`ENABLE_LO_POS +: 3];
                    channelOn[6*g + 3 +: 3] <= enables[g][`ENABLE_HI_POS +: 3];
                end
            end
        end
    endgenerate

    // read data taken at the idle edge that first sees the request, ready in the answer cycle; unmapped reads zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= `ENABLE_UNMAPPED_READ;
        end else if (busState == chan_enable_pkg::BUS_IDLE && req.read) begin
            readdata <= hit ? {24'h00_0000, enables[hitIdx] & `ENABLE_WRITABLE_MASK}
                            : `ENABLE_UNMAPPED_READ;
        end
    end

    // reset and read-path checks; the bench drives only legal requests
    property p_reset_disabled;
        @(posedge mclk) $rose(rst_n) |-> channelOn == 24'h00_0000;
    endproperty
    a_reset_disabled: assert property (p_reset_disabled) else $error("outputs not off after reset");

    property p_reserved_zero;
        @(posedge mclk) disable iff (!rst_n)
            !waitrequest && $past(req.read) |-> readdata[7] == 1'b0 && readdata[3] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one");

    // enables reach the outputs three edges after the request is seen
    property p_write_reaches_ab;
        @(posedge mclk) disable iff (!rst_n)
            busState == chan_enable_pkg::BUS_IDLE && write && address == `ENABLE_GROUPS_A_B_IDX && byteenable[0]
            |-> ##3 channelOn[5:0] == {$past(writedata[6:4], 3), $past(writedata[2:0], 3)};
    endproperty
    a_write_reaches_ab: assert property (p_write_reaches_ab) else $error("group a/b enables wrong");

    property p_write_reaches_cd;
        @(posedge mclk) disable iff (!rst_n)
            busState == chan_enable_pkg::BUS_IDLE && write && address == `ENABLE_GROUPS_C_D_IDX && byteenable[0]
            |-> ##3 channelOn[11:6] == {$past(writedata[6:4], 3), $past(writedata[2:0], 3)};
    endproperty
    a_write_reaches_cd: assert property (p_write_reaches_cd) else $error("group c/d enables wrong");

    property p_write_reaches_ef;
        @(posedge mclk) disable iff (!rst_n)
            busState == chan_enable_pkg::BUS_IDLE && write && address == `ENABLE_GROUPS_E_F_IDX && byteenable[0]
            |-> ##3 channelOn[17:12] == {$past(writedata[6:4], 3), $past(writedata[2:0], 3)};
    endproperty
    a_write_reaches_ef: assert property (p_write_reaches_ef) else $error("group e/f enables wrong");

    property p_write_reaches_gh;
        @(posedge mclk) disable iff (!rst_n)
            busState == chan_enable_pkg::BUS_IDLE && write && address == `ENABLE_GROUPS_G_H_IDX && byteenable[0]
            |-> ##3 channelOn[23:18] == {$past(writedata[6:4], 3), $past(writedata[2:0], 3)};
    endproperty
    a_write_reaches_gh: assert property (p_write_reaches_gh) else $error("group g/h enables wrong");

    // read back of the group c/d register agrees with what its outputs show
    property p_readback;
        @(posedge mclk) disable iff (!rst_n)
            busState == chan_enable_pkg::BUS_IDLE && read && address == `ENABLE_GROUPS_C_D_IDX
            |=> readdata[7:0] == {1'b0, channelOn[11:9], 1'b0, channelOn[8:6]};
    endproperty
    a_readback: assert property (p_readback) else $error("read back differs from outputs");

    // exactly one wait cycle, then waitrequest high again
    property p_one_wait;
        @(posedge mclk) disable iff (!rst_n)
            busState == chan_enable_pkg::BUS_IDLE && (read || write) |=> !waitrequest ##1 waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("answer timing wrong");

    // the hole just above the bank reads as zero
    property p_unmapped_zero;
        @(posedge mclk) disable iff (!rst_n)
            busState == chan_enable_pkg::BUS_IDLE && read && address == 8'(`ENABLE_GROUPS_G_H_IDX + 1)
            |=> readdata == `ENABLE_UNMAPPED_READ;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    // waitrequest low only in the answer state; a low while idle would end a request unanswered
    property p_wait_only_answer;
        @(posedge mclk) disable iff (!rst_n) !waitrequest |-> busState == chan_enable_pkg::BUS_ANSWER;
    endproperty
    a_wait_only_answer: assert property (p_wait_only_answer) else $error("waitrequest low outside answer");

    // read data stands until the next read is taken, so a slow master still sees it
    property p_readdata_holds;
        @(posedge mclk) disable iff (!rst_n)
            !(busState == chan_enable_pkg::BUS_IDLE && read) |=> $stable(readdata);
    endproperty
    a_readdata_holds: assert property (p_readdata_holds) else $error("read data changed without a read");

    // per-register checks; register r sits at the first index plus r
    generate
        for (genvar r = 0; r < `ENABLE_REG_COUNT; r++) begin : gen_chk
            // a write lands only at the answer edge, reserved bits masked
            property p_write_lands;
                @(posedge mclk) disable iff (!rst_n)
                    busState == chan_enable_pkg::BUS_ANSWER && write && !read && byteenable[0]
                    && address == 8'(`ENABLE_GROUPS_A_B_IDX + r)
                    |=> enables[r] == ($past(writedata[7:0]) & `ENABLE_WRITABLE_MASK);
            endproperty
            a_write_lands: assert property (p_write_lands) else $error("enable write did not land");

            // lane 0 off means the byte is not ours to change
            property p_lane_ignored;
                @(posedge mclk) disable iff (!rst_n)
                    busState == chan_enable_pkg::BUS_ANSWER && write && !byteenable[0]
                    |=> enables[r] == $past(enables[r]);
            endproperty
            a_lane_ignored: assert property (p_lane_ignored) else $error("masked write changed an enable");

            // outside an answered write the stored enables never move
            property p_held_without_write;
                @(posedge mclk) disable iff (!rst_n)
                    !(busState == chan_enable_pkg::BUS_ANSWER && write) |=> enables[r] == $past(enables[r]);
            endproperty
            a_held_without_write: assert property (p_held_without_write) else $error("enable moved");

            // reserved places are never stored, so no path can leak them
            property p_reserved_stored;
                @(posedge mclk) disable iff (!rst_n) enables[r][7] == 1'b0 && enables[r][3] == 1'b0;
            endproperty
            a_reserved_stored: assert property (p_reserved_stored) else $error("reserved bit stored");
        end
    endgenerate

    // main scenarios that the bench is expected to reach
    c_write_ab: cover property (@(posedge mclk) disable iff (!rst_n) write && address == 8'h40 && !waitrequest);
    c_read_gh: cover property (@(posedge mclk) disable iff (!rst_n) read && address == 8'h43 && !waitrequest);
    c_all_on: cover property (@(posedge mclk) disable iff (!rst_n) channelOn == 24'hFF_FFFF);
    c_lane_masked: cover property (@(posedge mclk) disable iff (!rst_n) write && !byteenable[0] && !waitrequest);
    c_unmapped_read: cover property (@(posedge mclk) disable iff (!rst_n) read && !hit && !waitrequest);
endmodule

// file: tb/tb_top.sv
// self-checking bench of the channel output enable bank
`timescale 1ns/10ps
module tb_top;
    logic        mclk;
    logic        rst_n;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [23:0] channelOn;
    logic [15:0] seed;
    logic [31:0] got;
    int          k;
    int          badCount;
    int          testsRun;
    chan_enable_pkg::enable_byte_t model [4];

    channel_output_enable_bank u_channel_output_enable_bank (
        .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .channelOn(channelOn));

    // 25 mhz bus clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // fibonacci step, repeatable from the fixed seed
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // low nibble feeds the lower group, high nibble the upper one
    function automatic logic [23:0] expect_on();
        logic [23:0] v;
        for (int r = 0; r < 4; r++) begin
            v[6*r +: 3] = model[r][2:0];
            v[6*r+3 +: 3] = model[r][6:4];
        end
        return v;
    endfunction

    // request held until waitrequest is sampled low; a dead slave is left to the watchdog
    task automatic bus(input logic [7:0] a, input logic rd, input logic [7:0] d, input logic [3:0] be);
        address <= a;
        read <= rd;
        write <= !rd;
        byteenable <= be;
        writedata <= {24'h00_0000, d};
        @(posedge mclk);
        while (waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        got = readdata;
    endtask

    // release after the answer edge; back-to-back calls skip this on purpose
    task automatic bus_idle();
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic check_rd(input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: readdata %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_on();
        testsRun++;
        if (channelOn !== expect_on()) begin
            badCount++;
            $display("Error at %0t: channelOn %h expected %h", $time, channelOn, expect_on());
        end
    endtask

    task automatic end_of_test();
        if (badCount == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a few hundred cycles expected; far beyond that means a hang
    initial begin
        repeat (4000) @(posedge mclk);
        badCount++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'h0;
        writedata = 32'h0000_0000;
        seed = 16'h000d;
        badCount = 0;
        testsRun = 0;
        foreach (model[i]) model[i] = 8'h00;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int p = 0; p < 60; p++) begin
            // first eight passes set all ones then clear, the rest are random
            seed = lfsr(seed);
            k = (p < 8) ? (p % 4) : int'(seed[9:8]);
            if (p < 4) begin
                bus(8'h40 + 8'(k), 1'b1, 8'h00, 4'h1);
                check_rd(32'h0000_0000);
            end
            bus(8'h40 + 8'(k), 1'b0, (p < 4) ? 8'hff : (p < 8) ? 8'h88 : seed[7:0], 4'h1);
            model[k] = ((p < 4) ? 8'hff : (p < 8) ? 8'h88 : seed[7:0]) & 8'h77;
            bus(8'h40 + 8'(k), 1'b1, 8'h00, 4'h1);
            check_rd({24'h00_0000, model[k]});
            check_on();
        end
        // lane 0 disabled, then unmapped places on both sides of the bank
        bus(8'h41, 1'b0, ~model[1], 4'he);
        bus(8'h41, 1'b1, 8'h00, 4'h1);
        check_rd({24'h00_0000, model[1]});
        bus(8'h44, 1'b0, 8'hff, 4'h1);
        bus(8'h44, 1'b1, 8'h00, 4'h1);
        check_rd(32'h0000_0000);
        bus(8'h3f, 1'b1, 8'h00, 4'h1);
        check_rd(32'h0000_0000);
        check_on();
        // reset in mid-run must drop every enable
        bus_idle();
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        foreach (model[i]) model[i] = 8'h00;
        check_on();
        rst_n <= 1'b1;
        bus(8'h43, 1'b1, 8'h00, 4'h1);
        check_rd(32'h0000_0000);
        bus_idle();
        end_of_test();
    end
endmodule
